// ==== spmlc_pkg.sv ====
// Shared constants and types for the port mode and indicator configuration
package spmlc_pkg;

    // Core clock and generated reference clock rates
    localparam int MCLK_FREQ_MHZ = 125;
    localparam int REF_CLOCK_MHZ = 50;
    // Phase accumulator for the reference clock: two toggles per period
    localparam int REF_ACC_MOD = MCLK_FREQ_MHZ;
    localparam logic [7:0] REF_ACC_STEP = 8'(2 * REF_CLOCK_MHZ);
    localparam logic [7:0] REF_ACC_LIMIT = 8'(REF_ACC_MOD);

    // Longest gap between edges of the external reference before loss
    localparam int REF_TIMEOUT_NS = 200;
    localparam int REF_TIMEOUT_CYCLES =
        (REF_TIMEOUT_NS * MCLK_FREQ_MHZ) / 1000;
    localparam logic [7:0] REF_TIMEOUT_COUNT = 8'(REF_TIMEOUT_CYCLES);

    // Cycles after reset release before straps are taken
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h2;

    // Positions in the synchroniser vector
    localparam int SYNC_WIDTH = 8;
    localparam int SYNC_LED_MODE = 0;
    localparam int SYNC_ROLE_LO = 1;
    localparam int SYNC_ROLE_HI = 2;
    localparam int SYNC_P1_IND0 = 3;
    localparam int SYNC_P2_IND0 = 4;
    localparam int SYNC_P1_IND1 = 5;
    localparam int SYNC_P4_TXC = 6;
    localparam int SYNC_XTAL = 7;

    // Values after reset
    localparam logic [1:0] ROLE_STRAP_RESET = 2'h0;
    localparam logic [SYNC_WIDTH-1:0] SYNC_RESET = 8'h00;

    // Role of the port 4 media interface
    typedef enum logic [1:0] {
        SPMLC_ROLE_PHY,
        SPMLC_ROLE_MAC,
        SPMLC_ROLE_OFF
    } spmlc_role_type;

    // Status of one copper port
    typedef struct packed {
        logic link;
        logic activity;
        logic speed100;
        logic full_duplex;
    } spmlc_port_status_type;

    // Captured strap configuration
    typedef struct packed {
        logic led_mode;
        logic [1:0] port4_role_strap;
        logic port1_indicator0_strap;
        logic port2_indicator0_strap;
        logic port1_indicator1_strap;
    } spmlc_strap_type;

endpackage

// ==== spmlc_top.sv ====
// Port mode selection, indicator drive and reference clock handling
`timescale 1ns/1ps
module spmlc_top (
    // Clock, reset and enable
    input wire logic mclk_in,
    input wire logic reset_n_in,
    input wire logic ce_in,
    // Strap pins and shared indicator pins
    input wire logic led_mode_strap_in,
    input wire logic [1:0] port4_role_strap_in,
    input wire logic port1_indicator0_strap_in,
    input wire logic port2_indicator0_strap_in,
    input wire logic port1_indicator1_strap_in,
    // Software configuration bits
    input wire logic led_mode_write_in,
    input wire logic led_mode_value_in,
    input wire logic port3_mac_select_in,
    input wire logic link_change_enable_in,
    input wire logic link_change_clear_in,
    // Copper port status
    input wire spmlc_pkg::spmlc_port_status_type [1:0] port_status_in,
    // Clock pins
    input wire logic crystal_input,
    input wire logic port4_transmit_clock_in,
    // Indicator pins, index 0 is port 1
    output logic [1:0] port_indicator_one_out,
    output logic [1:0] port_indicator_one_oe_out,
    output logic [1:0] port_indicator_zero_out,
    output logic [1:0] port_indicator_zero_oe_out,
    // Interrupt
    output logic link_change_irq_out,
    // Port configuration
    output spmlc_pkg::spmlc_role_type port4_role_out,
    output logic port3_mac_out,
    output logic port4_reduced_out,
    output logic port3_reduced_out,
    output logic rmii_clock_mode_out,
    output logic led_mode_out,
    output logic straps_done_out,
    // Reference clocks
    output logic core_clock_out,
    output logic ref_clock_ok_out,
    output logic port4_receive_clock_out,
    output logic port4_receive_clock_oe_out,
    output logic port3_receive_clock_out,
    output logic port3_receive_clock_oe_out
);
    import spmlc_pkg::*;

    // Decode of the port 4 role strap
    function automatic spmlc_role_type role_decode(input logic [1:0] bits);
        unique case (bits)
            2'h0: role_decode = SPMLC_ROLE_PHY;
            2'h3: role_decode = SPMLC_ROLE_MAC;
            default: role_decode = SPMLC_ROLE_OFF;
        endcase
    endfunction

    logic [SYNC_WIDTH-1:0] async_pins;
    logic [SYNC_WIDTH-1:0] sync1_reg;
    logic [SYNC_WIDTH-1:0] sync2_reg;
    spmlc_strap_type strap_reg;
    logic [1:0] settle_reg;
    logic done_reg;
    logic led_mode_reg;
    logic [1:0] link_prev_reg;
    logic irq_pend_reg;
    logic [7:0] acc_reg;
    logic [7:0] acc_sum;
    logic ref_gen_reg;
    logic txc_prev_reg;
    logic [7:0] gap_reg;
    logic [1:0] ind_one_next;
    logic [1:0] ind_zero_next;
    logic link_change;

    assign async_pins = {crystal_input, port4_transmit_clock_in,
                         port1_indicator1_strap_in, port2_indicator0_strap_in,
                         port1_indicator0_strap_in, port4_role_strap_in,
                         led_mode_strap_in};

    // Two-flop synchronisers for every pin input
    genvar gi;
    generate
        for (gi = 0; gi < SYNC_WIDTH; gi++) begin : g_sync
            always_ff @(posedge mclk_in or negedge reset_n_in) begin
                if (!reset_n_in) begin
                    sync1_reg[gi] <= SYNC_RESET[gi];
                    sync2_reg[gi] <= SYNC_RESET[gi];
                end else if (ce_in) begin
                    sync1_reg[gi] <= async_pins[gi];
                    sync2_reg[gi] <= sync1_reg[gi];
                end
            end
        end
    endgenerate

    // Strap capture once the synchronisers have filled after release
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            settle_reg <= 2'h0;
            done_reg <= 1'b0;
            strap_reg <= '0;
        end else if (ce_in && !done_reg) begin
            if (settle_reg == STRAP_SETTLE_CYCLES) begin
                done_reg <= 1'b1;
                strap_reg <= {sync2_reg[SYNC_LED_MODE],
                              sync2_reg[SYNC_ROLE_HI:SYNC_ROLE_LO],
                              sync2_reg[SYNC_P1_IND0],
                              sync2_reg[SYNC_P2_IND0],
                              sync2_reg[SYNC_P1_IND1]};
            end else begin
                settle_reg <= settle_reg + 2'h1;
            end
        end
    end

    // Indicator mode: strap value, then software writes override
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            led_mode_reg <= 1'b0;
        end else if (ce_in) begin
            if (led_mode_write_in) begin
                led_mode_reg <= led_mode_value_in;
            end else if (!done_reg && settle_reg == STRAP_SETTLE_CYCLES) begin
                led_mode_reg <= sync2_reg[SYNC_LED_MODE];
            end
        end
    end

    // Indicator functions per port, active high
    always_comb begin
        ind_one_next = '0;
        ind_zero_next = '0;
        for (int p = 0; p < 2; p++) begin
            if (!led_mode_reg) begin
                ind_one_next[p] = port_status_in[p].link &
                                  ~port_status_in[p].activity;
                ind_zero_next[p] = port_status_in[p].speed100;
            end else begin
                ind_one_next[p] = port_status_in[p].link &
                                  port_status_in[p].speed100 &
                                  ~port_status_in[p].activity;
                ind_zero_next[p] = port_status_in[p].full_duplex;
            end
        end
    end

    // Indicator pins released during strap sampling
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            port_indicator_one_out <= 2'h0;
            port_indicator_zero_out <= 2'h0;
            port_indicator_one_oe_out <= 2'h0;
            port_indicator_zero_oe_out <= 2'h0;
        end else if (ce_in) begin
            port_indicator_one_out <= ind_one_next;
            port_indicator_zero_out <= ind_zero_next;
            port_indicator_one_oe_out <= {2{done_reg}};
            port_indicator_zero_oe_out <= {2{done_reg}};
        end
    end

    assign link_change = |(link_prev_reg ^
                           {port_status_in[1].link, port_status_in[0].link});

    // Sticky link change flag, a new change wins over the clear
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            link_prev_reg <= 2'h0;
            irq_pend_reg <= 1'b0;
        end else if (ce_in) begin
            link_prev_reg <= {port_status_in[1].link, port_status_in[0].link};
            if (link_change) begin
                irq_pend_reg <= 1'b1;
            end else if (link_change_clear_in) begin
                irq_pend_reg <= 1'b0;
            end
        end
    end

    assign link_change_irq_out = irq_pend_reg &
                                 link_change_enable_in;

    // Port roles and interface types
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            port4_role_out <= SPMLC_ROLE_PHY;
            port3_mac_out <= 1'b0;
        end else if (ce_in) begin
            port4_role_out <= done_reg ?
                role_decode(strap_reg.port4_role_strap) :
                SPMLC_ROLE_PHY;
            port3_mac_out <= port3_mac_select_in;
        end
    end

    assign port4_reduced_out = done_reg &
                               ~strap_reg.port1_indicator0_strap;
    assign port3_reduced_out = done_reg &
                               ~strap_reg.port2_indicator0_strap;
    assign rmii_clock_mode_out = ~done_reg |
                                 strap_reg.port1_indicator1_strap;
    assign led_mode_out = led_mode_reg;
    assign straps_done_out = done_reg;

    // 50 MHz reference from the core clock by phase accumulation
    assign acc_sum = acc_reg + REF_ACC_STEP;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            acc_reg <= 8'h00;
            ref_gen_reg <= 1'b0;
        end else if (ce_in) begin
            if (acc_sum >= REF_ACC_LIMIT) begin
                acc_reg <= acc_sum - REF_ACC_LIMIT;
                ref_gen_reg <= ~ref_gen_reg;
            end else begin
                acc_reg <= acc_sum;
            end
        end
    end

    // Watch the external reference for edges
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            txc_prev_reg <= 1'b0;
            gap_reg <= 8'h00;
            ref_clock_ok_out <= 1'b0;
        end else if (ce_in) begin
            txc_prev_reg <= sync2_reg[SYNC_P4_TXC];
            if (sync2_reg[SYNC_P4_TXC] != txc_prev_reg) begin
                gap_reg <= 8'h00;
                ref_clock_ok_out <= 1'b1;
            end else if (gap_reg >= REF_TIMEOUT_COUNT) begin
                ref_clock_ok_out <= 1'b0;
            end else begin
                gap_reg <= gap_reg + 8'h01;
            end
        end
    end

    // Clock source selection and clock pin drive
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            core_clock_out <= 1'b0;
            port4_receive_clock_out <= 1'b0;
            port4_receive_clock_oe_out <= 1'b0;
            port3_receive_clock_out <= 1'b0;
            port3_receive_clock_oe_out <= 1'b0;
        end else if (ce_in) begin
            core_clock_out <= rmii_clock_mode_out ? sync2_reg[SYNC_XTAL] :
                              sync2_reg[SYNC_P4_TXC];
            port4_receive_clock_out <= ref_gen_reg;
            port4_receive_clock_oe_out <= rmii_clock_mode_out &
                (port4_reduced_out | port3_reduced_out);
            port3_receive_clock_out <= sync2_reg[SYNC_P4_TXC];
            port3_receive_clock_oe_out <= ~rmii_clock_mode_out &
                                          port3_reduced_out;
        end
    end

    // Helper: cycles since the generated reference last toggled
    logic [2:0] since_toggle_reg;
    logic ref_gen_prev_reg;
    always_ff @(posedge mclk_in or negedge reset_n_in) begin
        if (!reset_n_in) begin
            since_toggle_reg <= 3'h0;
            ref_gen_prev_reg <= 1'b1; // Differs from generator, no false stall
        end else if (ce_in) begin
            ref_gen_prev_reg <= ref_gen_reg;
            since_toggle_reg <= (ref_gen_reg != ref_gen_prev_reg) ? 3'h0 :
                                since_toggle_reg + 3'h1;
        end
    end

    chk_led_mode_zero: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        (ce_in && !led_mode_reg) |=> (port_indicator_zero_out[0] ==
            $past(port_status_in[0].speed100)))
        else $error("mode 0 speed indicator wrong");

    chk_led_mode_one: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        (ce_in && led_mode_reg) |=> (port_indicator_zero_out[1] ==
            $past(port_status_in[1].full_duplex)))
        else $error("mode 1 duplex indicator wrong");

    chk_irq_on_change: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        (ce_in && link_change && link_change_enable_in) ##1
            link_change_enable_in |-> link_change_irq_out)
        else $error("link change raised no interrupt");

    chk_role_before_done: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        !done_reg |-> (port4_role_out == SPMLC_ROLE_PHY && !port4_reduced_out))
        else $error("port 4 not PHY before straps");

    chk_port4_role_map: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        (done_reg && $past(done_reg) && $past(ce_in)) |->
            ((port4_role_out == SPMLC_ROLE_MAC) ==
             (strap_reg.port4_role_strap == 2'h3)))
        else $error("port 4 role does not follow strap");

    chk_port3_mac_sel: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        ce_in |=> (port3_mac_out == $past(port3_mac_select_in)))
        else $error("port 3 role does not follow select bit");

    chk_ref_toggles: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        since_toggle_reg < 3'h2)
        else $error("generated reference stalled");

    chk_port3_clock: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        (ce_in && !rmii_clock_mode_out && port3_reduced_out) |=>
            (port3_receive_clock_oe_out &&
             port3_receive_clock_out == $past(sync2_reg[SYNC_P4_TXC])))
        else $error("port 3 clock not forwarded");

    chk_strap_held: assert property (
        @(posedge mclk_in) disable iff (!reset_n_in)
        done_reg |=> (done_reg && $stable(strap_reg)))
        else $error("strap capture changed after sampling");

endmodule

// ==== spmlc_far_end.sv ====
// Far-end model: external reference source and port 3 link partner
`timescale 1ns/1ps
module spmlc_far_end (
    // Control from the bench
    input wire logic run_in,
    // Clock seen by the port 3 link partner
    input wire logic port3_clock_in,
    // Reference clock into the port 4 transmit clock pin
    output logic ref_clock_out,
    output int port3_edges_out
);
    initial ref_clock_out = 1'b0;
    initial port3_edges_out = 0;

    // Reference toggles every 32 ns, stands low outside a run
    // A released port 3 clock pin is seen low by the partner
    always begin
        #32;
        ref_clock_out = run_in ? ~ref_clock_out : 1'b0;
    end

    // Partner counts the rising reference edges it receives
    always @(posedge port3_clock_in) begin
        port3_edges_out = port3_edges_out + 1;
    end
endmodule

// ==== spmlc_top_tb.sv ====
// Self-checking bench for port mode and indicator configuration
`timescale 1ns/1ps
module spmlc_top_tb;
    import spmlc_pkg::*;
    logic mclk = 1'b0, rst_n = 1'b0, xtal = 1'b0, run = 1'b0, wr = 1'b0;
    logic lm = 1'b0, s0 = 1'b1, s2 = 1'b1, s1 = 1'b1, wv = 1'b0;
    logic p3m = 1'b0, ien = 1'b0, iclr = 1'b0, ce = 1'b1;
    logic [1:0] role = 2'h0, i1, i1oe, i0, i0oe;
    spmlc_port_status_type [1:0] st = '0;
    logic irq, p3mac, p4red, p3red, ckm, ledm, done, core, rok;
    logic p4rx, p4rxoe, p3rx, p3rxoe, txc;
    spmlc_role_type p4role;
    int edges, n, nc, e0, fail_count = 0, checks = 0;

    // Core clock and crystal
    always #4 mclk = ~mclk;
    always #20 xtal = ~xtal;

    spmlc_far_end far_u (.run_in(run), .port3_clock_in(p3rx & p3rxoe),
        .ref_clock_out(txc), .port3_edges_out(edges));

    spmlc_top dut_u (.mclk_in(mclk), .reset_n_in(rst_n), .ce_in(ce),
        .led_mode_strap_in(lm), .port4_role_strap_in(role),
        .port1_indicator0_strap_in(s0), .port2_indicator0_strap_in(s2),
        .port1_indicator1_strap_in(s1), .led_mode_write_in(wr),
        .led_mode_value_in(wv), .port3_mac_select_in(p3m),
        .link_change_enable_in(ien), .link_change_clear_in(iclr),
        .port_status_in(st), .crystal_input(xtal),
        .port4_transmit_clock_in(txc), .port_indicator_one_out(i1),
        .port_indicator_one_oe_out(i1oe), .port_indicator_zero_out(i0),
        .port_indicator_zero_oe_out(i0oe), .link_change_irq_out(irq),
        .port4_role_out(p4role), .port3_mac_out(p3mac),
        .port4_reduced_out(p4red), .port3_reduced_out(p3red),
        .rmii_clock_mode_out(ckm), .led_mode_out(ledm),
        .straps_done_out(done), .core_clock_out(core),
        .ref_clock_ok_out(rok), .port4_receive_clock_out(p4rx),
        .port4_receive_clock_oe_out(p4rxoe),
        .port3_receive_clock_out(p3rx),
        .port3_receive_clock_oe_out(p3rxoe));

    // Compare and count
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Reset with a strap set {led mode, role, ind0 p1, ind0 p2, ind1 p1}
    task automatic rst(input logic [5:0] cfg);
        @(negedge mclk);
        rst_n = 1'b0;
        {lm, role, s0, s2, s1} = cfg;
        repeat (4) @(negedge mclk);
        chk("role in reset", 8'(p4role), 8'(SPMLC_ROLE_PHY));
        chk("done in reset", 8'(done), 8'h0);
        rst_n = 1'b1;
        repeat (6) @(negedge mclk);
    endtask

    task automatic cyc(input int c);
        repeat (c) @(negedge mclk);
    endtask

    // Count rises of the port 4 clock pin and the core clock
    task automatic count(input int c);
        logic a, b;
        n = 0;
        nc = 0;
        a = p4rx;
        b = core;
        repeat (c) begin
            @(negedge mclk);
            if (p4rx && !a) n++;
            if (core && !b) nc++;
            a = p4rx;
            b = core;
        end
    endtask

    // Expected {one, zero} for a status {link, act, speed, duplex}
    function automatic logic [1:0] ind(input logic m, input logic [3:0] s);
        if (m) return {s[3] & s[1] & ~s[2], s[0]};
        return {s[3] & ~s[2], s[1]};
    endfunction

    function automatic spmlc_role_type exp_role(input logic [1:0] r);
        if (r == 2'h3) return SPMLC_ROLE_MAC;
        if (r == 2'h0) return SPMLC_ROLE_PHY;
        return SPMLC_ROLE_OFF;
    endfunction

    // Watchdog
    initial begin
        #300000;
        fail_count++;
        end_sim();
    end

    // Main sequence
    initial begin
        for (int k = 0; k < 4; k++) begin
            rst({k[0], 2'(k), k[0], k[1], ~k[0]});
            chk("port4 role", 8'(p4role), 8'(exp_role(2'(k))));
            chk("straps done", 8'(done), 8'h1);
            chk("port4 reduced", 8'(p4red), 8'(!k[0]));
            chk("port3 reduced", 8'(p3red), 8'(!k[1]));
            chk("clock mode", 8'(ckm), 8'(!k[0]));
            chk("strap led mode", 8'(ledm), 8'(k[0]));
            {lm, role, s0, s2, s1} = ~{lm, role, s0, s2, s1};
            cyc(4);
            chk("held role", 8'(p4role), 8'(exp_role(2'(k))));
            chk("held reduced", 8'(p4red), 8'(!k[0]));
        end
        chk("indicator oe", 8'({i1oe, i0oe}), 8'hf);
        for (int m = 0; m < 2; m++) begin
            wv = m[0];
            wr = 1'b1;
            cyc(1);
            wr = 1'b0;
            chk("written led mode", 8'(ledm), 8'(m[0]));
            for (int k = 0; k < 16; k++) begin
                st[0] = 4'(k);
                st[1] = ~4'(k);
                cyc(2);
                chk("port1 indicators", 8'({i1[0], i0[0]}),
                    8'(ind(m[0], 4'(k))));
                chk("port2 indicators", 8'({i1[1], i0[1]}),
                    8'(ind(m[0], ~4'(k))));
            end
        end
        p3m = 1'b1;
        cyc(2);
        chk("port3 mac", 8'(p3mac), 8'h1);
        ce = 1'b0;
        p3m = 1'b0;
        cyc(3);
        chk("frozen port3 mac", 8'(p3mac), 8'h1);
        ce = 1'b1;
        cyc(2);
        chk("port3 phy", 8'(p3mac), 8'h0);
        ien = 1'b1;
        iclr = 1'b1;
        cyc(1);
        iclr = 1'b0;
        cyc(1);
        chk("irq idle", 8'(irq), 8'h0);
        st[1].link = ~st[1].link;
        cyc(2);
        chk("irq on link change", 8'(irq), 8'h1);
        ien = 1'b0;
        cyc(1);
        chk("irq masked", 8'(irq), 8'h0);
        ien = 1'b1;
        iclr = 1'b1;
        cyc(1);
        iclr = 1'b0;
        cyc(1);
        chk("irq cleared", 8'(irq), 8'h0);
        rst(6'b000011);
        chk("port4 clock oe", 8'(p4rxoe), 8'h1);
        count(100);
        chk("50 MHz rises", 8'(n >= 39 && n <= 41), 8'h1);
        chk("core from crystal", 8'(nc >= 19 && nc <= 21), 8'h1);
        run = 1'b1;
        rst(6'b000100);
        chk("port3 clock oe", 8'(p3rxoe), 8'h1);
        chk("port4 clock off", 8'(p4rxoe), 8'h0);
        cyc(4);
        chk("reference ok", 8'(rok), 8'h1);
        e0 = edges;
        count(80);
        n = edges - e0;
        chk("port3 partner edges", 8'(n >= 9 && n <= 11), 8'h1);
        chk("core from reference", 8'(nc >= 9 && nc <= 11), 8'h1);
        run = 1'b0;
        cyc(40);
        chk("reference lost", 8'(rok), 8'h0);
        end_sim();
    end
endmodule
